// ---- verilog/mrf_framer.sv ----
// Purpose: builds binary metering response frames byte by byte
// Assumes: payload store answers src_byte in the same cycle
// Notes: frames leave through a 16-entry byte FIFO
`timescale 1ns/10ps
`default_nettype none
module mrf_framer
    import mrf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] req_code,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] model,
    input wire logic delta_conn,
    input wire logic rot_acb,
    input wire logic settings_changed,
    output logic settings_changed_flag,
    output logic [1:0] src_sel,
    output logic [7:0] src_addr,
    input wire logic [7:0] src_byte,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    // ****************************************
    // Channel name tables
    // ****************************************
    // names of the full variant channels
    function automatic logic [47:0] inst_name(input logic [4:0] ch,
                                              input logic dlt);
        case (ch)
            5'd0: inst_name = 48'h494100000000;
            5'd1: inst_name = 48'h494200000000;
            5'd2: inst_name = 48'h494300000000;
            5'd3: inst_name = 48'h494E00000000;
            5'd4: inst_name = dlt ? 48'h564142000000 : 48'h564100000000;
            5'd5: inst_name = dlt ? 48'h564243000000 : 48'h564200000000;
            5'd6: inst_name = dlt ? 48'h564341000000 : 48'h564300000000;
            5'd7: inst_name = 48'h565300000000;
            5'd8: inst_name = 48'h564E00000000;
            5'd9: inst_name = 48'h494138370000;
            5'd10: inst_name = 48'h494238370000;
            5'd11: inst_name = 48'h494338370000;
            5'd12: inst_name = 48'h465245510000;
            default: inst_name = 48'h564443000000;
        endcase
    endfunction

    function automatic logic [47:0] dem_name(input logic [4:0] ch);
        case (ch)
            5'd0: dem_name = 48'h494100000000;
            5'd1: dem_name = 48'h494200000000;
            5'd2: dem_name = 48'h494300000000;
            5'd3: dem_name = 48'h494E00000000;
            5'd4: dem_name = 48'h494700000000;
            5'd5: dem_name = 48'h334932000000;
            5'd6: dem_name = 48'h50412B000000;
            5'd7: dem_name = 48'h50422B000000;
            5'd8: dem_name = 48'h50432B000000;
            5'd9: dem_name = 48'h50332B000000;
            5'd10: dem_name = 48'h51412B000000;
            5'd11: dem_name = 48'h51422B000000;
            5'd12: dem_name = 48'h51432B000000;
            5'd13: dem_name = 48'h51332B000000;
            5'd14: dem_name = 48'h50412D000000;
            5'd15: dem_name = 48'h50422D000000;
            5'd16: dem_name = 48'h50432D000000;
            5'd17: dem_name = 48'h50332D000000;
            5'd18: dem_name = 48'h51412D000000;
            5'd19: dem_name = 48'h51422D000000;
            5'd20: dem_name = 48'h51432D000000;
            default: dem_name = 48'h51332D000000;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    mrf_state_t state_q;
    mrf_frame_t kind_q;
    logic [7:0] cmd_lo_q;
    logic [7:0] pos_q;
    logic [3:0] sub_q;
    logic [4:0] ch_q;
    logic [7:0] sum_q;
    logic [7:0] status_q;
    logic flag_q;
    logic [7:0] byte_c;
    logic [7:0] fifo_in;
    logic fifo_valid;
    logic fifo_ready;

    // ****************************************
    // Request decode
    // ****************************************
    logic take;
    logic is_cfg;
    logic is_dcfg;
    logic is_inst;
    logic is_dem;
    logic is_ack;
    logic emit;
    logic last;
    logic [7:0] frame_len;
    logic [7:0] ana_len;
    logic [7:0] time_pos;
    logic [7:0] bank_pos;
    logic [7:0] res_pos;
    logic in_chan;
    logic [7:0] tail_idx;
    logic [47:0] name_c;
    logic [7:0] line_cfg;

    // Requests are taken only between frames
    assign req_ready = (state_q == MRF_ST_IDLE);
    assign take = req_valid && req_ready;
    assign is_cfg = (req_code == MRF_CMD_CFG);
    assign is_dcfg = (req_code == MRF_CMD_DCFG) || (req_code == MRF_CMD_PCFG);
    assign is_inst = (req_code == MRF_CMD_INST);
    assign is_dem = (req_code == MRF_CMD_DEM) || (req_code == MRF_CMD_PEAK);
    assign is_ack = (req_code == MRF_CMD_ACK);

    assign ana_len = (model == MRF_MODEL_BASE) ? MRF_ANA_BASE :
                     (model == MRF_MODEL_DIFF) ? MRF_ANA_DIFF :
                     (model == MRF_MODEL_SYNC) ? MRF_ANA_SYNC : MRF_ANA_FULL;

    // Frame length selects the checksum position
    assign frame_len = (kind_q == MRF_FR_CFG) ? MRF_LEN_CFG :
                       (kind_q == MRF_FR_DCFG) ? MRF_LEN_DCFG :
                       (kind_q == MRF_FR_DEM) ? MRF_LEN_DEM :
                       (model == MRF_MODEL_BASE) ? MRF_LEN_BASE :
                       (model == MRF_MODEL_DIFF) ? MRF_LEN_DIFF :
                       (model == MRF_MODEL_SYNC) ? MRF_LEN_SYNC :
                       MRF_LEN_FULL;

    assign time_pos = MRF_DATA_HDR +
                      ((kind_q == MRF_FR_DEM) ? MRF_ANA_DEM : ana_len);
    assign bank_pos = time_pos + MRF_TIME_BYTES;
    assign res_pos = (kind_q == MRF_FR_DEM) ? bank_pos :
                     bank_pos + MRF_BANK_BYTES;

    // Channel region of configuration frames
    assign in_chan = (pos_q >= MRF_CFG_HDR) &&
                     (ch_q < ((kind_q == MRF_FR_CFG) ? MRF_CH_FULL[4:0] :
                              MRF_CH_DEM[4:0]));
    assign tail_idx = pos_q - MRF_CFG_HDR - 8'(MRF_CH_FULL * MRF_CH_BYTES);
    assign name_c = (kind_q == MRF_FR_CFG) ? inst_name(ch_q, delta_conn) :
                    dem_name(ch_q);

    assign line_cfg = (rot_acb ? MRF_ROT_ACB : 8'h00) +
                      (delta_conn ? MRF_CONN_DELTA : 8'h00);

    assign emit = (state_q == MRF_ST_SEND) && fifo_ready;
    assign last = (pos_q == frame_len - 8'h01);

    // ****************************************
    // Byte generator
    // ****************************************
    // Payload source address for the current data byte
    always_comb begin
        src_sel = MRF_SRC_ANA;
        src_addr = pos_q - MRF_DATA_HDR;
        if (kind_q == MRF_FR_DEM && pos_q < time_pos) begin
            src_sel = MRF_SRC_DEM;
        end else if (pos_q >= time_pos && pos_q < bank_pos) begin
            src_sel = MRF_SRC_TIME;
            src_addr = pos_q - time_pos;
        end else if (pos_q >= bank_pos) begin
            src_sel = MRF_SRC_BANK;
            src_addr = pos_q - bank_pos;
        end
    end

    // fields in order, most significant byte first
    always_comb begin
        byte_c = 8'h00;
        if (last) begin
            // modulo-256 sum of all earlier bytes
            byte_c = sum_q;
        end else if (pos_q == 8'h00) begin
            byte_c = MRF_SYNC_BYTE;
        end else if (pos_q == 8'h01) begin
            byte_c = cmd_lo_q;
        end else if (pos_q == 8'h02) begin
            byte_c = frame_len;
        end else if (kind_q == MRF_FR_INST || kind_q == MRF_FR_DEM) begin
            if (pos_q == 8'h03) begin
                byte_c = status_q;
            end else if (pos_q < res_pos) begin
                byte_c = src_byte;
            end
        end else if (pos_q < MRF_CFG_HDR) begin
            case (pos_q)
                8'h03: byte_c = MRF_STATUS_FLAGS;
                8'h06: byte_c = (kind_q == MRF_FR_CFG) ? MRF_CH_FULL :
                                MRF_CH_DEM;
                8'h07: byte_c = (kind_q == MRF_FR_CFG) ? MRF_SAMPLES_CFG :
                                MRF_SAMPLES_DEM;
                8'h08: byte_c = (kind_q == MRF_FR_CFG) ? MRF_BANKS_CFG :
                                8'h00;
                8'h09: byte_c = (kind_q == MRF_FR_CFG) ? MRF_CALC_CFG :
                                8'h00;
                8'h0A: byte_c = MRF_ANA_OFS[15:8];
                8'h0B: byte_c = MRF_ANA_OFS[7:0];
                8'h0C: byte_c = (kind_q == MRF_FR_CFG) ?
                                MRF_TS_OFS_CFG[15:8] : MRF_TS_OFS_DEM[15:8];
                8'h0D: byte_c = (kind_q == MRF_FR_CFG) ?
                                MRF_TS_OFS_CFG[7:0] : MRF_TS_OFS_DEM[7:0];
                8'h0E: byte_c = (kind_q == MRF_FR_CFG) ?
                                MRF_DIG_OFS_CFG[15:8] : MRF_DIG_OFS_DEM[15:8];
                8'h0F: byte_c = (kind_q == MRF_FR_CFG) ?
                                MRF_DIG_OFS_CFG[7:0] : MRF_DIG_OFS_DEM[7:0];
                default: byte_c = 8'h00;
            endcase
        end else if (in_chan) begin
            // name, channel type, scale factor fields
            case (sub_q)
                4'd6: byte_c = (kind_q == MRF_FR_CFG) ? MRF_CHTYPE_INST :
                               MRF_CHTYPE_DEM;
                4'd7: byte_c = MRF_SF_TYPE;
                4'd8: byte_c = 8'h00;
                4'd9: byte_c = 8'h00;
                default: byte_c = name_c[8'd47 - {sub_q, 3'b000} -: 8];
            endcase
        end else if (kind_q == MRF_FR_CFG) begin
            case (tail_idx)
                8'd0: byte_c = line_cfg;
                8'd1: byte_c = MRF_POWER_STD;
                8'd2, 8'd3, 8'd4,
                8'd5, 8'd6, 8'd7: byte_c = MRF_NONE_BYTE;
                8'd8: byte_c = 8'h00;
                8'd9: byte_c = 8'h01;
                8'd10: byte_c = 8'h02;
                8'd11: byte_c = 8'h04;
                8'd12: byte_c = 8'h05;
                8'd13: byte_c = 8'h06;
                default: byte_c = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= MRF_ST_IDLE;
            kind_q <= MRF_FR_CFG;
            cmd_lo_q <= 8'h00;
        end else begin
            case (state_q)
                MRF_ST_IDLE: begin
                    if (take && (is_cfg || is_dcfg || is_inst || is_dem)) begin
                        state_q <= MRF_ST_SEND;
                        cmd_lo_q <= req_code[7:0];
                        kind_q <= is_cfg ? MRF_FR_CFG :
                                  is_dcfg ? MRF_FR_DCFG :
                                  is_inst ? MRF_FR_INST : MRF_FR_DEM;
                    end
                end
                MRF_ST_SEND: begin
                    if (emit && last) begin
                        state_q <= MRF_ST_IDLE;
                    end
                end
                default: state_q <= MRF_ST_IDLE;
            endcase
        end
    end

    // Byte position, channel counters and running sum
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 8'h00;
            sub_q <= 4'd0;
            ch_q <= 5'd0;
            sum_q <= 8'h00;
        end else if (take) begin
            pos_q <= 8'h00;
            sub_q <= 4'd0;
            ch_q <= 5'd0;
            sum_q <= 8'h00;
        end else if (emit) begin
            pos_q <= pos_q + 8'h01;
            sum_q <= sum_q + byte_c;
            if (in_chan) begin
                sub_q <= (sub_q == 4'd9) ? 4'd0 : sub_q + 4'd1;
                ch_q <= (sub_q == 4'd9) ? ch_q + 5'd1 : ch_q;
            end
        end
    end

    // ****************************************
    // Settings-changed flag
    // ****************************************
    // set at reset and on change; a set beats an acknowledge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b1;
        end else if (settings_changed) begin
            flag_q <= 1'b1;
        end else if (take && is_ack) begin
            flag_q <= 1'b0;
        end
    end

    // only bit 4 is used, captured when the frame is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 8'h00;
        end else if (take) begin
            status_q <= 8'(flag_q) << MRF_FLAG_BIT;
        end
    end

    assign settings_changed_flag = flag_q;

    // ****************************************
    // Output buffer
    // ****************************************
    // Back-pressure from the port stalls the sequencer via fifo_ready
    assign fifo_in = byte_c;
    assign fifo_valid = (state_q == MRF_ST_SEND);

    mrf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(fifo_in),
        .in_valid(fifo_valid),
        .in_ready(fifo_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );
endmodule
`default_nettype wire

// ---- pkg/mrf_pkg.sv ----
// Purpose: constants shared by the metering response framer
// Assumes: byte-wide frames, most significant byte first
// Notes: frame length byte equals the total number of bytes in the frame
package mrf_pkg;
    // ****************************************
    // Request codes
    // ****************************************
    localparam logic [15:0] MRF_CMD_CFG = 16'hA5C1;
    localparam logic [15:0] MRF_CMD_DCFG = 16'hA5C2;
    localparam logic [15:0] MRF_CMD_PCFG = 16'hA5C3;
    localparam logic [15:0] MRF_CMD_INST = 16'hA5D1;
    localparam logic [15:0] MRF_CMD_DEM = 16'hA5D2;
    localparam logic [15:0] MRF_CMD_PEAK = 16'hA5D3;
    localparam logic [15:0] MRF_CMD_ACK = 16'hA5B9;

    // ****************************************
    // Frame lengths and section sizes
    // ****************************************
    localparam logic [7:0] MRF_LEN_CFG = 8'hAC;
    localparam logic [7:0] MRF_LEN_DCFG = 8'hEE;
    localparam logic [7:0] MRF_LEN_BASE = 8'h94;
    localparam logic [7:0] MRF_LEN_DIFF = 8'hAC;
    localparam logic [7:0] MRF_LEN_SYNC = 8'h9C;
    localparam logic [7:0] MRF_LEN_FULL = 8'hB4;
    localparam logic [7:0] MRF_LEN_DEM = 8'hBE;
    localparam logic [7:0] MRF_ANA_BASE = 8'h50;  // 80 bytes
    localparam logic [7:0] MRF_ANA_DIFF = 8'h68;  // 104 bytes
    localparam logic [7:0] MRF_ANA_SYNC = 8'h58;  // 88 bytes
    localparam logic [7:0] MRF_ANA_FULL = 8'h70;  // 112 bytes
    localparam logic [7:0] MRF_ANA_DEM = 8'hB0;   // 176 bytes
    localparam logic [7:0] MRF_TIME_BYTES = 8'h08;
    localparam logic [7:0] MRF_BANK_BYTES = 8'h36; // 54 banks
    localparam logic [7:0] MRF_DATA_HDR = 8'h04;
    localparam logic [7:0] MRF_CFG_HDR = 8'h10;   // 16 header bytes
    localparam logic [7:0] MRF_CH_BYTES = 8'h0A;  // name, type, sf
    localparam logic [7:0] MRF_CH_FULL = 8'h0E;
    localparam logic [7:0] MRF_CH_DEM = 8'h16;

    // ****************************************
    // Configuration block field values
    // ****************************************
    localparam logic [7:0] MRF_SYNC_BYTE = 8'hA5;
    localparam logic [7:0] MRF_STATUS_FLAGS = 8'h01;
    localparam logic [7:0] MRF_SAMPLES_CFG = 8'h02;
    localparam logic [7:0] MRF_SAMPLES_DEM = 8'h01;
    localparam logic [7:0] MRF_BANKS_CFG = 8'h36;
    localparam logic [7:0] MRF_CALC_CFG = 8'h01;
    localparam logic [15:0] MRF_ANA_OFS = 16'h0004;
    localparam logic [15:0] MRF_TS_OFS_CFG = 16'h0074;
    localparam logic [15:0] MRF_DIG_OFS_CFG = 16'h007C;
    localparam logic [15:0] MRF_TS_OFS_DEM = 16'h00B4;
    localparam logic [15:0] MRF_DIG_OFS_DEM = 16'hFFFF;
    localparam logic [7:0] MRF_CHTYPE_INST = 8'h01;
    localparam logic [7:0] MRF_CHTYPE_DEM = 8'h02;
    localparam logic [7:0] MRF_SF_TYPE = 8'hFF;
    localparam logic [7:0] MRF_POWER_STD = 8'h00;
    localparam logic [7:0] MRF_NONE_BYTE = 8'hFF; // deskew, Rs, Xs
    localparam logic [7:0] MRF_ROT_ACB = 8'h01;
    localparam logic [7:0] MRF_CONN_DELTA = 8'h02;
    localparam int MRF_FLAG_BIT = 4;

    // ****************************************
    // Variants, payload sources, states
    // ****************************************
    localparam logic [1:0] MRF_MODEL_BASE = 2'h0;
    localparam logic [1:0] MRF_MODEL_DIFF = 2'h1;
    localparam logic [1:0] MRF_MODEL_SYNC = 2'h2;
    localparam logic [1:0] MRF_MODEL_FULL = 2'h3;
    localparam logic [1:0] MRF_SRC_ANA = 2'h0;
    localparam logic [1:0] MRF_SRC_TIME = 2'h1;
    localparam logic [1:0] MRF_SRC_BANK = 2'h2;
    localparam logic [1:0] MRF_SRC_DEM = 2'h3;

    typedef enum logic [1:0] {
        MRF_FR_CFG,
        MRF_FR_DCFG,
        MRF_FR_INST,
        MRF_FR_DEM
    } mrf_frame_t;

    typedef enum logic {
        MRF_ST_IDLE,
        MRF_ST_SEND
    } mrf_state_t;
endpackage

// ---- verilog/mrf_fifo.sv ----
// Purpose: byte FIFO between the frame builder and the serial port
// Assumes: single clock, first-word presented from registers
// Notes: depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module mrf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("mrf_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];

    // Storage array, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- test/mrf_properties.sv ----
// Purpose: port checks of the framer
// Assumes: bound into mrf_framer
// Notes: one clock domain
`timescale 1ns/10ps
`default_nettype none
module mrf_properties
    import mrf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] req_code,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic settings_changed,
    input wire logic settings_changed_flag,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready
);
    // ************
    // Properties
    // ************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Taken request; an acknowledge clears at the next edge
    wire tk = req_valid && req_ready;
    wire ack = tk && req_code == MRF_CMD_ACK;
    property p_set;
        settings_changed |=> settings_changed_flag;
    endproperty
    a_set: assert property (p_set)
        else $error("flag not set");
    property p_hold;
        settings_changed_flag && !ack && !$past(ack) |=> settings_changed_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag lost");
    property p_ack;
        ack && !settings_changed |=> !settings_changed_flag;
    endproperty
    a_ack: assert property (p_ack)
        else $error("flag not cleared");
    property p_first;
        tk && req_code == MRF_CMD_INST && !tx_valid
            |-> ##2 tx_valid && tx_data == MRF_SYNC_BYTE;
    endproperty
    a_first: assert property (p_first)
        else $error("bad first byte");
    property p_busy;
        tk && req_code == MRF_CMD_DEM |=> !req_ready [*8];
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready too soon");
    property p_ackq;
        ack && !tx_valid |=> !tx_valid [*2];
    endproperty
    a_ackq: assert property (p_ackq)
        else $error("bytes after ack");
    property p_txhold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_txhold: assert property (p_txhold)
        else $error("byte changed");
    property p_idle;
        req_ready && !req_valid && !tx_valid |=> !tx_valid;
    endproperty
    a_idle: assert property (p_idle)
        else $error("stray byte");
endmodule
bind mrf_framer mrf_properties #(.FIFO_DEPTH(FIFO_DEPTH)) mrf_properties_inst (
    .clk(clk), .nrst(nrst), .req_code(req_code), .req_valid(req_valid),
    .req_ready(req_ready), .settings_changed(settings_changed),
    .settings_changed_flag(settings_changed_flag), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready)
);
`default_nettype wire

// ---- test/mrf_host_model.sv ----
// Purpose: polling host draining frames
// Assumes: one byte per handshake
// Notes: stall halves the take rate
`timescale 1ns/10ps
`default_nettype none
module mrf_host_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic clr,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready = 1'b0
);
    logic [7:0] rx [0:255];
    int n_rx = 0;
    logic tog = 1'b0;
    // Slow mode lets the FIFO fill up
    always @(negedge clk) begin
        tog <= ~tog;
        tx_ready <= ~stall | tog;
    end
    // Store accepted bytes of one frame
    always @(posedge clk) begin
        if (clr)
            n_rx <= 0;
        else if (tx_valid && tx_ready) begin
            rx[n_rx[7:0]] <= tx_data;
            n_rx <= n_rx + 1;
        end
    end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the framer
// Assumes: payload byte is {src_sel,6'h00}^src_addr
// Notes: host model keeps each frame
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import mrf_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, delta_conn = 1'b0;
    logic rot_acb = 1'b0, settings_changed = 1'b0, stall = 1'b0, clr = 1'b0;
    logic [15:0] req_code = 16'h0000;
    logic [1:0] model = 2'h0, src_sel;
    logic req_ready, flag, tx_valid, tx_ready;
    logic [7:0] src_addr, src_byte, tx_data;
    int n_fail = 0;
    int n_tests = 0;
    // Payload store answers at once
    assign src_byte = {src_sel, 6'h00} ^ src_addr;
    mrf_framer #(.FIFO_DEPTH(16)) mrf_framer_inst (.clk(clk), .nrst(nrst),
        .req_code(req_code), .req_valid(req_valid), .req_ready(req_ready),
        .model(model), .delta_conn(delta_conn), .rot_acb(rot_acb),
        .settings_changed(settings_changed), .settings_changed_flag(flag),
        .src_sel(src_sel), .src_addr(src_addr), .src_byte(src_byte),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    mrf_host_model mrf_host_model_inst (.clk(clk), .stall(stall), .clr(clr),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] fb(int p);
        return mrf_host_model_inst.rx[p];
    endfunction
    // Hold the request until taken
    task automatic req(logic [15:0] c);
        @(negedge clk);
        clr = 1'b1;
        req_code = c;
        req_valid = 1'b1;
        while (!req_ready) @(negedge clk);
        @(negedge clk);
        clr = 1'b0;
        req_valid = 1'b0;
    endtask
    // Fetch a frame; header, size, sum
    task automatic get(logic [15:0] c, logic [7:0] len);
        logic [7:0] s;
        int i;
        s = 8'h00;
        req(c);
        for (i = 0; i < 3000 && mrf_host_model_inst.n_rx < len; i++)
            @(negedge clk);
        repeat (4) @(negedge clk);
        chk("count", len, 8'(mrf_host_model_inst.n_rx));
        chk("sync", c[15:8], fb(0));
        chk("cmd", c[7:0], fb(1));
        chk("length", len, fb(2));
        for (i = 0; i < len - 1; i++)
            s = s + fb(i);
        chk("checksum", s, fb(len - 1));
    endtask
    task automatic t_inst;
        logic [7:0] ln [4] = '{8'h94, 8'hAC, 8'h9C, 8'hB4};
        int an [4] = '{80, 104, 88, 112};
        for (int m = 0; m < 4; m++) begin
            model = 2'(m);
            stall = (m == 3);
            get(MRF_CMD_INST, ln[m]);
            chk("status", 8'h10, fb(3));
            chk("analog", 8'(an[m] - 1), fb(3 + an[m]));
            chk("time", 8'h40, fb(4 + an[m]));
            chk("bank", 8'hB5, fb(65 + an[m]));
            chk("rsv", 8'h00, fb(66 + an[m]));
        end
        stall = 1'b0;
    endtask
    task automatic t_ack;
        req(MRF_CMD_ACK);
        @(negedge clk);
        chk("flag ack", 8'h00, {7'h00, flag});
        get(MRF_CMD_INST, 8'hB4);
        chk("status clr", 8'h00, fb(3));
        settings_changed = 1'b1;
        @(negedge clk);
        settings_changed = 1'b0;
        chk("flag set", 8'h01, {7'h00, flag});
        get(MRF_CMD_INST, 8'hB4);
        chk("status set", 8'h10, fb(3));
    endtask
    task automatic t_cfg;
        logic [15:0] t [18] = '{16'h060E, 16'h0702, 16'h0836, 16'h0B04,
            16'h0D74, 16'h0F7C, 16'h3E01, 16'h3FFF, 16'h4100, 16'h9D00,
            16'h9EFF, 16'hA3FF, 16'hA400, 16'hA602, 16'hA704, 16'hA906,
            16'hAA00, 16'h0901};
        for (int k = 0; k < 4; k++) begin
            rot_acb = k[0];
            delta_conn = k[1];
            get(MRF_CMD_CFG, 8'hAC);
            chk("volt name", k[1] ? 8'h42 : 8'h00, fb(58));
            chk("line cfg", 8'(k), fb(156));
        end
        for (int k = 0; k < 18; k++)
            chk("cfg", t[k][7:0], fb(t[k][15:8]));
    endtask
    task automatic t_dem;
        logic [15:0] t [11] = '{16'h0616, 16'h0701, 16'h0800, 16'h0900,
            16'h0C00, 16'h0DB4, 16'h0EFF, 16'h0FFF, 16'h1602, 16'hE802,
            16'hEC00};
        get(MRF_CMD_DCFG, 8'hEE);
        for (int k = 0; k < 11; k++)
            chk("dcfg", t[k][7:0], fb(t[k][15:8]));
        get(MRF_CMD_PCFG, 8'hEE);
        chk("pcfg type", 8'h02, fb(22));
        get(MRF_CMD_DEM, 8'hBE);
        get(MRF_CMD_PEAK, 8'hBE);
        chk("dem last", 8'h6F, fb(179));
        chk("dem time", 8'h40, fb(180));
        chk("dem rsv", 8'h00, fb(188));
    endtask
    task automatic report_and_stop;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    // Watchdog far past the expected run
    initial begin
        #200000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_inst;
        t_ack;
        t_cfg;
        t_dem;
        report_and_stop;
    end
endmodule
`default_nettype wire
